// *** isr_cfg.svh ***
// Constants for the two-wire register-access link: addresses, opcodes and timing counts
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

`define ISR_SLAVE_ADDR     7'h20
`define ISR_GCALL_ADDR     8'h00
// Broadcast identity value is arbitrary
`define ISR_BCAST_ID       8'h5A
`define ISR_ACK_BIT        4'h8
`define ISR_LAST_BIT       4'h7

`define ISR_OP_START       2'h0
`define ISR_OP_WRITE       2'h1
`define ISR_OP_READ        2'h2
`define ISR_OP_STOP        2'h3

`define ISR_CORE_FREQ_KHZ  50000
`define ISR_LINK_PERIOD_NS 64
`define ISR_TIMEOUT_US     25000
`define ISR_TIMEOUT_CYC    ((`ISR_TIMEOUT_US * 1000) / `ISR_LINK_PERIOD_NS)
`define ISR_SCL_KHZ        100
`define ISR_SCL_QTR_CYC    (`ISR_CORE_FREQ_KHZ / (4 * `ISR_SCL_KHZ))
`define ISR_FIFO_DEPTH     16

`endif

// *** isr_pkg.sv ***
// Types shared by both ends of the register-access link
package isr_pkg;

   typedef enum logic [2:0] {
      ISR_D_IDLE,
      ISR_D_ADDR,
      ISR_D_GCID,
      ISR_D_PTR,
      ISR_D_WDATA,
      ISR_D_RDATA,
      ISR_D_IGNORE
   } isr_dev_state_t;

   typedef enum logic [1:0] {
      ISR_H_IDLE,
      ISR_H_START,
      ISR_H_BYTE,
      ISR_H_STOP
   } isr_host_state_t;

endpackage

// *** isr_link_if.sv ***
// Two-wire link between master and slave, with open-drain resolution of the data line
`timescale 1ns/100ps
`default_nettype none

interface isr_link_if;
   logic scl;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic sda;

   // Wired-AND with pull-up: low whenever either side drives low
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

   modport host   (output scl, output sda_m_o, output sda_m_oe, input sda);
   modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

`default_nettype wire

// *** isr_fifo.sv ***
// Command FIFO with registered valid and ready flags
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module isr_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = `ISR_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   // Depth is assumed a power of two so the pointers wrap naturally
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = AW + 1;

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [CW-1:0]    cnt;

   wire          push     = in_valid & in_ready;
   wire          pop      = out_valid & out_ready;
   wire [CW-1:0] next_cnt = CW'(cnt + CW'(push) - CW'(pop));

   assign out_data = mem[rp];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp        <= '0;
         rp        <= '0;
         cnt       <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wp        <= push ? AW'(wp + 1'b1) : wp;
         rp        <= pop ? AW'(rp + 1'b1) : rp;
         cnt       <= next_cnt;
         in_ready  <= next_cnt != CW'(DEPTH);
         out_valid <= next_cnt != '0;
      end
   end
endmodule

`default_nettype wire

// *** isr_host.sv ***
// Bus master end: runs queued start, byte and stop commands on the two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module isr_host #(
   parameter int unsigned QTR_CYC = `ISR_SCL_QTR_CYC,
   parameter int unsigned DEPTH   = `ISR_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Command stream
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [1:0] cmd_op,
   input  wire logic [7:0] cmd_data,
   // Byte results
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_ack,
   output logic            busy,
   // Serial link
   isr_link_if.host        lnk
);
   localparam int unsigned QW = $clog2(QTR_CYC + 1);

   isr_pkg::isr_host_state_t st;
   logic [1:0]    ph;
   logic [3:0]    bcnt;
   logic [8:0]    tx;
   logic [8:0]    rx;
   logic [QW-1:0] qcnt;
   logic          scl;
   logic          oe;
   logic          sq1;
   logic          sda_in;
   logic          f_valid;
   logic [9:0]    f_data;

   wire idle   = st == isr_pkg::ISR_H_IDLE;
   wire f_take = idle;
   wire pop    = idle & f_valid;
   wire tick   = qcnt == QW'(QTR_CYC - 1);
   wire [1:0] f_op = f_data[9:8];

   ////////////////////////////////////////////////////////////////////////////
   isr_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_isr_fifo (
      .clk       (core_clk),
      .rst_n     (rst_n),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   ({cmd_op, cmd_data}),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data)
   );

   // Master owns the clock; it is never released to a slave
   assign lnk.scl      = scl;
   assign lnk.sda_m_o  = 1'b0;
   assign lnk.sda_m_oe = oe;

   ////////////////////////////////////////////////////////////////////////////
   // Data line comes back through the slave, so it is synchronised
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sq1    <= 1'b1;
         sda_in <= 1'b1;
      end else begin
         sq1    <= lnk.sda;
         sda_in <= sq1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || idle || tick) begin
         qcnt <= '0;
      end else begin
         qcnt <= QW'(qcnt + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st        <= isr_pkg::ISR_H_IDLE;
         ph        <= 2'h0;
         bcnt      <= 4'h0;
         tx        <= 9'h1FF;
         rx        <= 9'h000;
         scl       <= 1'b1;
         oe        <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
         rsp_ack   <= 1'b0;
         busy      <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         busy      <= ~idle | f_valid;
         if (pop) begin
            ph   <= 2'h0;
            bcnt <= 4'h0;
            unique case (f_op)
               `ISR_OP_START: st <= isr_pkg::ISR_H_START;
               `ISR_OP_STOP:  st <= isr_pkg::ISR_H_STOP;
               `ISR_OP_WRITE: begin
                  st <= isr_pkg::ISR_H_BYTE;
                  tx <= {f_data[7:0], 1'b1};
               end
               `ISR_OP_READ: begin
                  st <= isr_pkg::ISR_H_BYTE;
                  tx <= {8'hFF, ~f_data[0]};
               end
            endcase
         end else if (!idle && tick) begin
            ph <= 2'(ph + 1'b1);
            unique case (st)
               isr_pkg::ISR_H_START: begin
                  // Release, raise clock, drop data: also a repeated start
                  unique case (ph)
                     2'h0: oe  <= 1'b0;
                     2'h1: scl <= 1'b1;
                     2'h2: oe  <= 1'b1;
                     2'h3: begin
                        scl <= 1'b0;
                        st  <= isr_pkg::ISR_H_IDLE;
                     end
                  endcase
               end
               isr_pkg::ISR_H_STOP: begin
                  unique case (ph)
                     2'h0: oe  <= 1'b1;
                     2'h1: scl <= 1'b1;
                     2'h2: oe  <= 1'b0;
                     2'h3: st  <= isr_pkg::ISR_H_IDLE;
                  endcase
               end
               isr_pkg::ISR_H_BYTE: begin
                  // Data changes only while the clock is low
                  unique case (ph)
                     2'h0: begin
                        oe <= ~tx[8];
                        tx <= {tx[7:0], 1'b1};
                     end
                     2'h1: scl <= 1'b1;
                     2'h2: rx  <= {rx[7:0], sda_in};
                     2'h3: begin
                        scl <= 1'b0;
                        if (bcnt == `ISR_ACK_BIT) begin
                           st        <= isr_pkg::ISR_H_IDLE;
                           rsp_valid <= 1'b1;
                           rsp_data  <= rx[8:1];
                           rsp_ack   <= ~rx[0];
                        end else begin
                           bcnt <= 4'(bcnt + 1'b1);
                        end
                     end
                  endcase
               end
               isr_pkg::ISR_H_IDLE: begin
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// *** isr_device.sv ***
// Slave end: register pointer, register array and write notifications for the two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module isr_device #(
   parameter int unsigned TIMEOUT_CYC = `ISR_TIMEOUT_CYC
) (
   // Clocks and reset
   input  wire logic  core_clk,
   input  wire logic  link_clk,
   input  wire logic  rst_n,
   // Serial link
   isr_link_if.device lnk,
   // Register write notifications, core clock
   output logic       wr_valid,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data
);
   localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

   isr_pkg::isr_dev_state_t st;
   isr_pkg::isr_dev_state_t after;
   isr_pkg::isr_dev_state_t next_after;

   logic [7:0]    mem [0:255];
   logic          lrst_q1;
   logic          lrst_n;
   logic          scl_q1;
   logic          scl_s;
   logic          scl_d;
   logic          sda_q1;
   logic          sda_s;
   logic          sda_d;
   logic [3:0]    bcnt;
   logic [7:0]    sh;
   logic [7:0]    tx;
   logic [7:0]    ptr;
   logic          oe;
   logic          mack;
   logic          next_ack;
   logic [TW-1:0] tmo;
   logic          wr_tog;
   logic [7:0]    wa;
   logic [7:0]    wd;
   logic          tq1;
   logic          tq2;
   logic          tq3;

   ////////////////////////////////////////////////////////////////////////////
   // Line conditions, all from the synchronised copies
   wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
   wire scl_rise   = scl_s & ~scl_d;
   wire scl_fall   = ~scl_s & scl_d;
   wire ack_slot   = bcnt == `ISR_ACK_BIT;
   wire last_bit   = bcnt == `ISR_LAST_BIT;
   wire addr_hit   = sh[7:1] == `ISR_SLAVE_ADDR;
   wire gcall_hit  = sh == `ISR_GCALL_ADDR;
   wire id_hit     = sh == `ISR_BCAST_ID;
   wire line_moved = (scl_s ^ scl_d) | (sda_s ^ sda_d);
   wire line_low   = ~scl_s | ~sda_s;
   wire tmo_hit    = tmo == TW'(TIMEOUT_CYC);
   wire active     = (st != isr_pkg::ISR_D_IDLE) & (st != isr_pkg::ISR_D_IGNORE);
   wire edge_fall  = scl_fall & active & ~tmo_hit;
   wire byte_end   = edge_fall & last_bit;
   wire mem_we     = byte_end & (st == isr_pkg::ISR_D_WDATA);
   wire [7:0] ptr_inc = 8'(ptr + 8'h01);
   wire [7:0] rd_cur  = mem[ptr];
   wire [7:0] rd_next = mem[ptr_inc];

   // Only ever pulls low; the clock is never driven
   assign lnk.sda_s_o  = 1'b0;
   assign lnk.sda_s_oe = oe;

   ////////////////////////////////////////////////////////////////////////////
   // Address and byte decode at the end of each eighth bit
   always_comb begin
      next_ack   = 1'b0;
      next_after = isr_pkg::ISR_D_IGNORE;
      unique case (st)
         isr_pkg::ISR_D_ADDR: begin
            if (addr_hit) begin
               next_ack   = 1'b1;
               next_after = sh[0] ? isr_pkg::ISR_D_RDATA : isr_pkg::ISR_D_PTR;
            end else if (gcall_hit) begin
               next_ack   = 1'b1;
               next_after = isr_pkg::ISR_D_GCID;
            end
         end
         isr_pkg::ISR_D_GCID: begin
            // Broadcast carries no read path, only the pointer byte next
            if (id_hit) begin
               next_ack   = 1'b1;
               next_after = isr_pkg::ISR_D_PTR;
            end
         end
         isr_pkg::ISR_D_PTR,
         isr_pkg::ISR_D_WDATA: begin
            next_ack   = 1'b1;
            next_after = isr_pkg::ISR_D_WDATA;
         end
         isr_pkg::ISR_D_IDLE,
         isr_pkg::ISR_D_RDATA,
         isr_pkg::ISR_D_IGNORE: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link-side reset and pin synchronisers
   always_ff @(posedge link_clk) begin
      lrst_q1 <= rst_n;
      lrst_n  <= lrst_q1;
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         scl_q1 <= 1'b1;
         scl_s  <= 1'b1;
         scl_d  <= 1'b1;
         sda_q1 <= 1'b1;
         sda_s  <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_q1 <= lnk.scl;
         scl_s  <= scl_q1;
         scl_d  <= scl_s;
         sda_q1 <= lnk.sda;
         sda_s  <= sda_q1;
         sda_d  <= sda_s;
      end
   end

   // Any line activity restarts the count; idle bus never times out
   always_ff @(posedge link_clk) begin
      if (!lrst_n || line_moved || !line_low || st == isr_pkg::ISR_D_IDLE) begin
         tmo <= '0;
      end else if (!tmo_hit) begin
         tmo <= TW'(tmo + 1'b1);
      end
   end

   // Cleared at reset so a read of an unwritten register is defined
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= 8'h00;
         end
      end else if (mem_we) begin
         mem[ptr] <= sh;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         st     <= isr_pkg::ISR_D_IDLE;
         after  <= isr_pkg::ISR_D_IDLE;
         bcnt   <= 4'h0;
         sh     <= 8'h00;
         tx     <= 8'h00;
         ptr    <= 8'h00;
         oe     <= 1'b0;
         mack   <= 1'b0;
         wr_tog <= 1'b0;
         wa     <= 8'h00;
         wd     <= 8'h00;
      end else if (tmo_hit) begin
         st <= isr_pkg::ISR_D_IDLE;
         oe <= 1'b0;
      end else if (start_cond) begin
         st   <= isr_pkg::ISR_D_ADDR;
         // First clock fall after a start carries no bit; it wraps this to zero
         bcnt <= 4'hF;
         oe   <= 1'b0;
      end else if (stop_cond) begin
         // Pointer keeps whatever the transfer left in it
         st <= isr_pkg::ISR_D_IDLE;
         oe <= 1'b0;
      end else begin
         if (scl_rise && active) begin
            if (!ack_slot) begin
               sh <= {sh[6:0], sda_s};
            end else begin
               mack <= ~sda_s;
            end
         end
         if (byte_end) begin
            bcnt <= `ISR_ACK_BIT;
            if (st == isr_pkg::ISR_D_RDATA) begin
               oe <= 1'b0;
            end else begin
               oe    <= next_ack;
               after <= next_after;
               if (st == isr_pkg::ISR_D_PTR) begin
                  ptr <= sh;
               end
               if (st == isr_pkg::ISR_D_WDATA) begin
                  ptr    <= ptr_inc;
                  wa     <= ptr;
                  wd     <= sh;
                  wr_tog <= ~wr_tog;
               end
            end
         end else if (edge_fall && ack_slot) begin
            bcnt <= 4'h0;
            if (st == isr_pkg::ISR_D_RDATA) begin
               if (mack) begin
                  ptr <= ptr_inc;
                  oe  <= ~rd_next[7];
                  tx  <= {rd_next[6:0], 1'b0};
               end else begin
                  st <= isr_pkg::ISR_D_IGNORE;
                  oe <= 1'b0;
               end
            end else begin
               st <= after;
               if (after == isr_pkg::ISR_D_RDATA) begin
                  oe <= ~rd_cur[7];
                  tx <= {rd_cur[6:0], 1'b0};
               end else begin
                  oe <= 1'b0;
               end
            end
         end else if (edge_fall) begin
            bcnt <= 4'(bcnt + 1'b1);
            if (st == isr_pkg::ISR_D_RDATA) begin
               oe <= ~tx[7];
               tx <= {tx[6:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write events cross by toggle; address and data are held for a whole
   // byte time, far longer than the synchroniser delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tq1      <= 1'b0;
         tq2      <= 1'b0;
         tq3      <= 1'b0;
         wr_valid <= 1'b0;
         wr_addr  <= 8'h00;
         wr_data  <= 8'h00;
      end else begin
         tq1      <= wr_tog;
         tq2      <= tq1;
         tq3      <= tq2;
         wr_valid <= tq2 ^ tq3;
         if (tq2 ^ tq3) begin
            wr_addr <= wa;
            wr_data <= wd;
         end
      end
   end
endmodule

`default_nettype wire

// *** isr_link_assertions.sv ***
// Device-side protocol checks on the host-device link
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module isr_link_assertions (
   // Clock and reset
   input wire logic link_clk,
   input wire logic rst_n,
   // Link signals
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_o,
   input wire logic sda_s_oe
);
   ////////////////////////////////////////////////////////////////////////
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bitc;
   logic [1:0] nbyte;
   logic [7:0] sh;
   logic [7:0] adr;
   wire logic  rise  = scl & ~scl_q;
   wire logic  start = scl & scl_q & sda_q & ~sda;
   wire logic  stop  = scl & scl_q & ~sda_q & sda;
   wire logic  ack9  = rise & (bitc == 4'h8);

   // Bit and byte position since the last start
   always_ff @(posedge link_clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (!rst_n || start) begin
         bitc  <= 4'h0;
         nbyte <= 2'h0;
      end else if (rise) begin
         bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
         if (bitc == 4'h8 && nbyte != 2'h3)
            nbyte <= nbyte + 2'h1;
         if (bitc < 4'h8)
            sh <= {sh[6:0], sda};
         if (bitc == 4'h7 && nbyte == 2'h0)
            adr <= {sh[6:0], sda};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge link_clk);
   endclocking
   default disable iff (!rst_n);

   a_open_drain_only: assert property (sda_s_oe |-> !sda_s_o)
      else $error("slave drives data high");
   a_steady_while_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
      else $error("slave data moved while clock high");
   a_quiet_after_start: assert property (start |=> !sda_s_oe [*8])
      else $error("slave drives during address");
   a_free_after_stop: assert property (stop |=> !sda_s_oe [*4])
      else $error("slave drives after stop");
   a_addr_acked: assert property (ack9 && nbyte == 2'h0 && adr[7:1] == `ISR_SLAVE_ADDR |-> sda_s_oe)
      else $error("own address not acknowledged");
   a_foreign_ignored: assert property (ack9 && nbyte == 2'h0 && adr[7:1] != `ISR_SLAVE_ADDR
      && adr != `ISR_GCALL_ADDR |-> !sda_s_oe)
      else $error("foreign address acknowledged");
   a_bad_id_ignored: assert property (ack9 && nbyte == 2'h1 && adr == `ISR_GCALL_ADDR
      && sh != `ISR_BCAST_ID |-> !sda_s_oe)
      else $error("wrong broadcast id acknowledged");
   a_id_acked: assert property (ack9 && nbyte == 2'h1 && adr == `ISR_GCALL_ADDR
      && sh == `ISR_BCAST_ID |-> sda_s_oe)
      else $error("broadcast id not acknowledged");
   a_write_acked: assert property (ack9 && nbyte != 2'h0 && adr == {`ISR_SLAVE_ADDR, 1'b0} |-> sda_s_oe)
      else $error("written byte not acknowledged");
   a_read_ack_master: assert property (ack9 && nbyte != 2'h0 && adr == {`ISR_SLAVE_ADDR, 1'b1} |-> !sda_s_oe)
      else $error("slave drives master acknowledge");
endmodule

`default_nettype wire

// *** i2c_slave_register_access_tb_top.sv ***
// Bench: host and device across the link, plus a stalled second link
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module i2c_slave_register_access_tb_top;
   logic        core_clk;
   logic        link_clk;
   logic        rst_n;
   logic        cmd_valid;
   logic        cmd_ready;
   logic [1:0]  cmd_op;
   logic [7:0]  cmd_data;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        rsp_ack;
   logic        busy;
   logic        wr_valid;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [8:0]  rq[$];
   logic [15:0] wq[$];
   logic [7:0]  d0;
   logic [7:0]  d1;
   logic [7:0]  adr_w;
   int          error_cnt;
   int          check_count;
   int          seed;

   isr_link_if lnk();
   isr_link_if lnk2();

   isr_host #(.QTR_CYC(13), .DEPTH(16)) u_isr_host (.core_clk(core_clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .busy(busy), .lnk(lnk));
   isr_device #(.TIMEOUT_CYC(2000)) u_isr_device (.core_clk(core_clk), .link_clk(link_clk),
      .rst_n(rst_n), .lnk(lnk), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
   // Second device faces the bench, which stalls its clock line
   isr_device #(.TIMEOUT_CYC(2000)) u_isr_device_b (.core_clk(core_clk), .link_clk(link_clk),
      .rst_n(rst_n), .lnk(lnk2), .wr_valid(), .wr_addr(), .wr_data());
   isr_link_assertions u_isr_link_assertions (.link_clk(link_clk), .rst_n(rst_n), .scl(lnk.scl),
      .sda(lnk.sda), .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stall();
      error_cnt++;
      $display("[FAIL] %0t ns: wait ran out", $time);
      finish_test();
   endtask

   // Request held until the edge where ready is high
   task automatic cmd(input logic [1:0] op, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      n = 0;
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      if (n >= 20000)
         stall();
   endtask

   task automatic st();
      cmd(2'h0, 8'h00);
   endtask
   task automatic sp();
      cmd(2'h3, 8'h00);
   endtask
   task automatic wb(input logic [7:0] d, input logic a);
      rq.push_back({d, a});
      cmd(2'h1, d);
   endtask
   task automatic rb(input logic [7:0] d, input logic a);
      rq.push_back({d, a});
      cmd(2'h2, {7'h00, a});
   endtask
   task automatic ev(input logic [7:0] a, input logic [7:0] d);
      wq.push_back({a, d});
   endtask

   task automatic idle();
      int n;
      n = 0;
      repeat (4) @(posedge core_clk);
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20000)
         stall();
      repeat (40) @(posedge core_clk);
   endtask

   task automatic bb(input logic c, input logic oe, input int n);
      lnk2.scl <= c;
      lnk2.sda_m_oe <= oe;
      repeat (n) @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Results come back in order, so each takes the oldest note
   always @(posedge core_clk) begin
      if (rsp_valid === 1'b1) begin
         if (rq.size() == 0)
            chk(16'h0001, 16'h0000);
         else
            chk({7'h00, rsp_data, rsp_ack}, {7'h00, rq.pop_front()});
      end
      if (wr_valid === 1'b1) begin
         if (wq.size() == 0)
            chk(16'h0001, 16'h0000);
         else
            chk({wr_addr, wr_data}, wq.pop_front());
      end
   end

   initial begin
      seed = 16;
      error_cnt = 0;
      check_count = 0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_data = 8'h00;
      adr_w = 8'h40;
      lnk2.scl = 1'b1;
      lnk2.sda_m_o = 1'b0;
      lnk2.sda_m_oe = 1'b0;
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      // Write across the pointer wrap; queued deep enough to fill the FIFO
      st();
      wb(8'h40, 1'b1);
      wb(8'hFE, 1'b1);
      ev(8'hFE, 8'h11);
      wb(8'h11, 1'b1);
      ev(8'hFF, 8'h22);
      wb(8'h22, 1'b1);
      ev(8'h00, 8'h33);
      wb(8'h33, 1'b1);
      sp();
      st();
      wb(8'h40, 1'b1);
      wb(8'hFE, 1'b1);
      st();
      wb(8'h41, 1'b1);
      rb(8'h11, 1'b1);
      rb(8'h22, 1'b1);
      rb(8'h33, 1'b0);
      sp();
      // Pointer only, then a plain read
      st();
      wb(8'h40, 1'b1);
      wb(8'h80, 1'b1);
      sp();
      st();
      wb(8'h41, 1'b1);
      rb(8'h00, 1'b0);
      sp();
      idle();
      // Broadcast data, then broadcast pointer and a plain read
      st();
      wb(8'h00, 1'b1);
      wb(`ISR_BCAST_ID, 1'b1);
      wb(8'h10, 1'b1);
      ev(8'h10, d0);
      wb(d0, 1'b1);
      ev(8'h11, d1);
      wb(d1, 1'b1);
      sp();
      st();
      wb(8'h00, 1'b1);
      wb(`ISR_BCAST_ID, 1'b1);
      wb(8'h11, 1'b1);
      sp();
      st();
      wb(8'h41, 1'b1);
      rb(d1, 1'b0);
      sp();
      // Foreign address and wrong broadcast id
      st();
      wb(8'h44, 1'b0);
      wb(8'h12, 1'b0);
      sp();
      st();
      wb(8'h00, 1'b1);
      wb(8'h77, 1'b0);
      sp();
      idle();
      // Stall the clock low at the address acknowledge
      bb(1'b1, 1'b1, 20);
      bb(1'b0, 1'b1, 10);
      for (int i = 7; i >= 0; i--) begin
         bb(1'b0, ~adr_w[i], 8);
         bb(1'b1, ~adr_w[i], 16);
      end
      bb(1'b0, 1'b0, 30);
      chk({15'h0000, lnk2.sda_s_oe}, 16'h0001);
      repeat (7000) @(posedge core_clk);
      chk({15'h0000, lnk2.sda_s_oe}, 16'h0000);
      chk(16'(rq.size()), 16'h0000);
      chk(16'(wq.size()), 16'h0000);
      finish_test();
   end
endmodule

`default_nettype wire
